// File: dv/pps_port_monitor.sv
// Purpose: Port-level checks for pps_port
// Assumes: bound to every pps_port
// Notes: status lines sampled at the read strobe
`timescale 1ns/1ps
module pps_port_monitor (
   // System
   input wire CLK,
   input wire SYS_RST,
   // Host bus
   input wire [1:0] ADDR,
   input wire RD,
   input wire [7:0] RDATA,
   input wire RDATA_OE,
   // Lines
   input wire EPP_ENABLE,
   input wire ERROR_N,
   input wire SELECTED,
   input wire PAPER_END,
   input wire ACK_N,
   input wire BUSY,
   input wire IRQ_A_OE,
   input wire IRQ_B_OE,
   input wire INIT_N_OE,
   input wire INIT_N_OUT
);
   wire st_rd = RD && ADDR == 2'h1;
   addr_none_a: assert property (@(posedge CLK) disable iff (SYS_RST) RD && ADDR == 2'h3 |=> !RDATA_OE)
      else $error("unmapped read answered");
   read_answer_a: assert property (@(posedge CLK) disable iff (SYS_RST) RD && ADDR != 2'h3 |=> RDATA_OE)
      else $error("read not answered");
   st_rsvd_a: assert property (@(posedge CLK) disable iff (SYS_RST) st_rd |=> RDATA[1])
      else $error("status bit 1 low");
   st_lines_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      st_rd |=> RDATA[6:3] == $past({ACK_N, PAPER_END, SELECTED, ERROR_N})) else $error("status lines wrong");
   st_busy_a: assert property (@(posedge CLK) disable iff (SYS_RST) st_rd |=> RDATA[7] == !$past(BUSY))
      else $error("busy bit wrong");
   ctl_rsvd_a: assert property (@(posedge CLK) disable iff (SYS_RST) RD && ADDR == 2'h2 |=> &RDATA[7:6])
      else $error("control bits 7:6 low");
   to_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST) st_rd && !EPP_ENABLE |=> RDATA[0])
      else $error("timeout bit low outside epp");
   reset_pins_a: assert property (@(posedge CLK) SYS_RST |-> !IRQ_A_OE && !IRQ_B_OE && INIT_N_OE && !INIT_N_OUT)
      else $error("reset pin states wrong");
endmodule // pps_port_monitor

bind pps_port pps_port_monitor u_mon (.CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .RD(RD), .RDATA(RDATA),
   .RDATA_OE(RDATA_OE), .EPP_ENABLE(EPP_ENABLE), .ERROR_N(ERROR_N), .SELECTED(SELECTED),
   .PAPER_END(PAPER_END), .ACK_N(ACK_N), .BUSY(BUSY), .IRQ_A_OE(IRQ_A_OE), .IRQ_B_OE(IRQ_B_OE),
   .INIT_N_OE(INIT_N_OE), .INIT_N_OUT(INIT_N_OUT));

// File: dv/pps_printer_model.sv
// Purpose: Printer side of the port pins
// Assumes: pins resolved here, pull-ups on control lines
// Notes: released data lines show the printer byte
`timescale 1ns/1ps
module pps_printer_model (
   // Data lines
   input wire [7:0] pd_out,
   input wire pd_oe,
   input wire [7:0] peer_pd,
   output wire [7:0] pd_in,
   // Control lines: init, select-in, auto-feed, strobe
   input wire [3:0] c_out,
   input wire [3:0] c_oe,
   output wire [3:0] c_in,
   // Status lines: busy, ack, paper end, selected, error
   input wire [4:0] st_set,
   output wire [4:0] st
);
   assign pd_in = pd_oe ? pd_out : peer_pd;
   // Floated control lines rise to the pull-up
   assign c_in = (c_out & c_oe) | ~c_oe;
   assign st = st_set;
endmodule // pps_printer_model

// File: dv/tb.sv
// Purpose: Self-checking bench for pps_port
// Assumes: printer model on the far side
// Notes: random bytes from a fixed seed
`timescale 1ns/1ps
module tb;
   reg clk = 1'b0, sys_rst = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
   reg bidir = 1'b0, irq_sel = 1'b0, epp_en = 1'b0, epp_wait = 1'b0, hold = 1'b0;
   reg [1:0] addr = 2'h0;
   reg [7:0] wdata = 8'h00, peer_pd = 8'hA5, d, v;
   reg [4:0] sts = 5'h1F;
   wire [7:0] rdata, pd_in, pd_out;
   wire pd_oe, ready, rdoe, rev_out;
   wire [3:0] c_in, c_out, c_oe;
   wire [4:0] st;
   wire [1:0] irq, irq_oe;
   integer seed = 16420, bad_count = 0, compares = 0, i;
   always #5 clk = ~clk;
   pps_port DUT (.CLK(clk), .SYS_RST(sys_rst), .ADDR(addr), .RD(rd_s), .WR(wr_s), .WDATA(wdata),
      .RDATA(rdata), .RDATA_OE(rdoe), .WR_READY(ready), .BIDIR_MODE_SELECT(bidir), .IRQ_LINE_SELECT(irq_sel),
      .EPP_ENABLE(epp_en), .EPP_REV_1284(1'b1), .ECP_ENABLE(1'b0), .STATUS_IRQ_ENABLE(1'b0),
      .EPP_CYCLE_WAIT(epp_wait), .PORT_HOLD(hold), .PORT_DATA_IN(pd_in), .PORT_DATA_OUT(pd_out),
      .PORT_DATA_OE(pd_oe), .DATA_STROBE_N_IN(c_in[0]), .DATA_STROBE_N_OUT(c_out[0]),
      .DATA_STROBE_N_OE(c_oe[0]), .AUTO_FEED_N_IN(c_in[1]), .AUTO_FEED_N_OUT(c_out[1]),
      .AUTO_FEED_N_OE(c_oe[1]), .SELECT_IN_N_IN(c_in[2]), .SELECT_IN_N_OUT(c_out[2]),
      .SELECT_IN_N_OE(c_oe[2]), .INIT_N_IN(c_in[3]), .INIT_N_OUT(c_out[3]), .INIT_N_OE(c_oe[3]),
      .ERROR_N(st[0]), .SELECTED(st[1]), .PAPER_END(st[2]), .ACK_N(st[3]), .BUSY(st[4]),
      .IRQ_A_OUT(irq[0]), .IRQ_A_OE(irq_oe[0]), .IRQ_B_OUT(irq[1]), .IRQ_B_OE(irq_oe[1]),
      .EPP_REV_1284_OUT(rev_out));
   pps_printer_model u_prn (.pd_out(pd_out), .pd_oe(pd_oe), .peer_pd(peer_pd), .pd_in(pd_in),
      .c_out(c_out), .c_oe(c_oe), .c_in(c_in), .st_set(sts), .st(st));
   ////////////////////////////////////////
   function [7:0] exp_st(input [4:0] s);
      exp_st = {~s[4], s[3:0], 3'b111};
   endfunction
   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [1:0] a, input [7:0] x);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= x;
         wr_s <= 1'b1;
         @(posedge clk);
         wr_s <= 1'b0;
      end
   endtask
   task rd(input [1:0] a);
      begin
         @(posedge clk);
         addr <= a;
         rd_s <= 1'b1;
         @(posedge clk);
         rd_s <= 1'b0;
         #1 d = rdata;
      end
   endtask
   task stop_test;
      begin
         $display("compares %0d bad_count %0d", compares, bad_count);
         if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   ////////////////////////////////////////
   initial begin
      #200000 bad_count = bad_count + 1;
      stop_test;
   end
   initial begin
      sys_rst <= 1'b1;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rd(2'h0);
      chk(d, 8'h00);
      rd(2'h3);
      chk({7'h0, rdoe}, 8'h00);
      for (i = 0; i < 12; i = i + 1) begin
         @(posedge clk);
         v = $random(seed);
         sts <= v[4:0];
         irq_sel <= v[7];
         wr(2'h0, v);
         wr(2'h1, ~v);
         wr(2'h3, ~v);
         rd(2'h0);
         chk(d, v);
         chk(pd_out, v);
         rd(2'h1);
         chk(d, exp_st(sts));
         wr(2'h2, v);
         rd(2'h2);
         chk(d, {3'b111, v[4:0]});
         chk({4'h0, c_out}, {4'h0, v[2], ~v[3], ~v[1], ~v[0]});
         chk({6'h0, irq_oe}, {6'h0, irq_sel & v[4], ~irq_sel & v[4]});
      end
      $display("compatible test done");
      bidir <= 1'b1;
      irq_sel <= 1'b1;
      wr(2'h2, 8'h24);
      peer_pd <= 8'hC3;
      rd(2'h0);
      chk(d, 8'hC3);
      chk({7'h0, pd_oe}, 8'h00);
      wr(2'h0, 8'h5A);
      wr(2'h2, 8'h14);
      rd(2'h0);
      chk(pd_out, 8'h5A);
      sts <= 5'h17;
      repeat (2) @(posedge clk);
      sts <= 5'h1F;
      repeat (3) @(posedge clk);
      chk({6'h0, irq_oe[1], irq[1]}, 8'h03);
      rd(2'h1);
      chk({7'h0, d[2]}, 8'h00);
      rd(2'h1);
      chk({7'h0, d[2]}, 8'h01);
      wr(2'h2, 8'h04);
      bidir <= 1'b0;
      $display("extended test done");
      hold <= 1'b1;
      v = 8'h10;
      for (i = 0; i < 4; i = i + 1) begin
         wr(2'h0, v);
         v = v + 8'h01;
      end
      @(posedge clk);
      #1 chk({7'h0, ready}, 8'h00);
      wr(2'h0, 8'hEE);
      hold <= 1'b0;
      repeat (10) @(posedge clk);
      rd(2'h0);
      chk(d, 8'h13);
      chk({7'h0, ready}, 8'h01);
      $display("buffer test done");
      wr(2'h2, 8'h04);
      epp_en <= 1'b1;
      rd(2'h1);
      chk({7'h0, d[0]}, 8'h00);
      chk({7'h0, rev_out}, 8'h01);
      wr(2'h2, 8'h24);
      rd(2'h2);
      chk(d, 8'hE4);
      wr(2'h2, 8'h04);
      epp_wait <= 1'b1;
      repeat (1005) @(posedge clk);
      epp_wait <= 1'b0;
      rd(2'h1);
      chk({7'h0, d[0]}, 8'h01);
      rd(2'h1);
      chk({7'h0, d[0]}, 8'h00);
      epp_en <= 1'b0;
      rd(2'h1);
      chk({7'h0, d[0]}, 8'h01);
      $display("epp test done");
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      #1 chk({1'b0, c_out[3], c_oe, irq_oe}, 8'h20);
      @(posedge clk);
      sys_rst <= 1'b0;
      rd(2'h0);
      chk(d, 8'h00);
      $display("reset test done");
      stop_test;
   end
endmodule // tb

// File: rtl/pps_defines.vh
// Purpose: Constants for the printer port register block
// Assumes: 100 MHz system clock
// Notes: Offsets are host address values on the two-bit port address
`ifndef PPS_DEFINES_VH
`define PPS_DEFINES_VH

// Register addresses
`define PPS_ADDR_DATA 2'h0
`define PPS_ADDR_STATUS 2'h1
`define PPS_ADDR_CONTROL 2'h2
`define PPS_ADDR_NONE 2'h3

// Control register fields
`define PPS_CTL_STROBE 0
`define PPS_CTL_AUTOFEED 1
`define PPS_CTL_INIT 2
`define PPS_CTL_SELIN 3
`define PPS_CTL_IRQEN 4
`define PPS_CTL_DIR 5

// Status register fields
`define PPS_ST_TIMEOUT 0
`define PPS_ST_RSVD 1
`define PPS_ST_IRQ 2

// Reset values
`define PPS_DATA_RST 8'h00
`define PPS_CTL_RST 6'h00

// ENHANCED_PORT_MODE cycle timeout, least time
`define PPS_CLK_PERIOD_NS 10
`define PPS_EPP_TIMEOUT_NS 10000
`define PPS_EPP_TIMEOUT_CYC ((`PPS_EPP_TIMEOUT_NS + `PPS_CLK_PERIOD_NS - 1) / `PPS_CLK_PERIOD_NS)
`define PPS_TO_CNT_W 10

`endif

// File: rtl/pps_port.v
// Purpose: Standard printer port data, status and control registers
// Assumes: Host strobes and pins synchronous to CLK; SYS_RST is master reset
// Notes: Data writes pass a small FIFO before reaching the port latch
//
// Summary of operation
// - Address 0 data, 1 status, 2 control; address 3 leaves host bus undriven.
// - Bidirectional mode select bit chooses Compatible (0) or Extended (1).
// - Compatible: writes drive port lines; reads return last written byte.
// - Extended: writes latch; direction 0 drives lines, direction 1 reads lines.
// - Data register is zero after reset.
// - Status register is read-only; writes change nothing.
// - ENHANCED_PORT_MODE timeout after 10 us sets status bit 0; a status read clears it.
// - ENHANCED_PORT_MODE enable rising clears timeout bit; outside ENHANCED_PORT_MODE it reads 1.
// - Status bit 1 always reads 1.
// - Status bit 2 is 1 or active-low interrupt status depending on mode.
// - Extended with irq enable: ack rising latches bit 2 low; read sets it.
// - Status bits 3..6 show error, select, paper end, acknowledge lines.
// - Status bit 7 is inverse of busy line.
// - Control bits 0, 1, 3 drive strobe, auto-feed, select-in inverted.
// - Control bit 2 drives initialise line non-inverted.
// - Irq line select chooses which of two interrupt lines is used.
// - Irq enable 0 floats line; otherwise behaviour depends on mode.
// - Direction bit acts only in bidirectional mode; reads 1 outside ENHANCED_PORT_MODE.
// - Control bits 6 and 7 read as 1.
// - Control bits 0..3 read actual pin levels, so external forcing is visible.
// - Master reset floats select-in, auto-feed, strobe, irqs; initialise low.
// - ENHANCED_PORT_MODE enable and ENHANCED_PORT_MODE revision configuration inputs are provided.
`timescale 1ns/1ps
`include "pps_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module pps_fifo #(
   parameter W = 8,
   parameter D = 4,
   parameter AW = 2
) (
   // System
   input wire clk,
   input wire rst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   wire push;
   wire pop;

   assign in_ready = (cnt_r != D[AW:0]);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data = mem[rp_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
         end
         if (push & ~pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop & ~push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // pps_fifo

////////////////////////////////////////////////////////////////////////////////
module pps_port #(
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW = 2
) (
   // System
   input wire CLK,
   input wire SYS_RST,
   // Host register access
   input wire [1:0] ADDR,
   input wire RD,
   input wire WR,
   input wire [7:0] WDATA,
   output reg [7:0] RDATA,
   output reg RDATA_OE,
   output reg WR_READY,
   // Configuration levels
   input wire BIDIR_MODE_SELECT,
   input wire IRQ_LINE_SELECT,
   input wire EPP_ENABLE,
   input wire EPP_REV_1284,
   input wire ECP_ENABLE,
   input wire STATUS_IRQ_ENABLE,
   // ENHANCED_PORT_MODE wait and data FIFO drain hold
   input wire EPP_CYCLE_WAIT,
   input wire PORT_HOLD,
   // Port data lines
   input wire [7:0] PORT_DATA_IN,
   output reg [7:0] PORT_DATA_OUT,
   output reg PORT_DATA_OE,
   // Printer control lines, active low on the wire
   input wire DATA_STROBE_N_IN,
   output reg DATA_STROBE_N_OUT,
   output reg DATA_STROBE_N_OE,
   input wire AUTO_FEED_N_IN,
   output reg AUTO_FEED_N_OUT,
   output reg AUTO_FEED_N_OE,
   input wire SELECT_IN_N_IN,
   output reg SELECT_IN_N_OUT,
   output reg SELECT_IN_N_OE,
   input wire INIT_N_IN,
   output reg INIT_N_OUT,
   output reg INIT_N_OE,
   // Printer status lines
   input wire ERROR_N,
   input wire SELECTED,
   input wire PAPER_END,
   input wire ACK_N,
   input wire BUSY,
   // Interrupt lines
   output reg IRQ_A_OUT,
   output reg IRQ_A_OE,
   output reg IRQ_B_OUT,
   output reg IRQ_B_OE,
   // ENHANCED_PORT_MODE status
   output reg EPP_REV_1284_OUT
);
   reg [7:0] data_latch_r;
   reg [5:0] ctl_r;
   reg timeout_r;
   reg irq_stat_n_r;
   reg ack_d_r;
   reg epp_en_d_r;
   reg live_r;
   reg [`PPS_TO_CNT_W-1:0] to_cnt_r;
   reg to_fired_r;
   reg irq_lvl;
   reg [7:0] st_val;
   reg [7:0] ctl_val;
   reg [7:0] rd_val;
   wire compat_mode;
   wire dir_in;
   wire ack_rise;
   wire ack_fall;
   wire to_event;
   wire rd_status;
   wire fifo_ready;
   wire fifo_valid;
   wire [7:0] fifo_data;
   wire stat_irq_used;
   wire [`PPS_TO_CNT_W-1:0] to_limit;
   // Timeout count trimmed to the counter width on purpose
   localparam integer TO_CYC = `PPS_EPP_TIMEOUT_CYC;

   assign compat_mode = ~BIDIR_MODE_SELECT;
   assign dir_in = BIDIR_MODE_SELECT & ctl_r[`PPS_CTL_DIR];
   assign ack_rise = ACK_N & ~ack_d_r;
   assign ack_fall = ~ACK_N & ack_d_r;
   assign rd_status = RD & (ADDR == `PPS_ADDR_STATUS);
   assign to_limit = TO_CYC[`PPS_TO_CNT_W-1:0];
   assign to_event = EPP_ENABLE & EPP_CYCLE_WAIT & (to_cnt_r == to_limit - 1'b1) & ~to_fired_r;
   assign stat_irq_used = (EPP_ENABLE | ECP_ENABLE) ? STATUS_IRQ_ENABLE : BIDIR_MODE_SELECT;

   pps_fifo #(
      .W(8),
      .D(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(CLK),
      .rst(SYS_RST),
      .in_valid(WR & (ADDR == `PPS_ADDR_DATA)),
      .in_ready(fifo_ready),
      .in_data(WDATA),
      .out_valid(fifo_valid),
      .out_ready(~PORT_HOLD),
      .out_data(fifo_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   always @* begin
      st_val = 8'h00;
      st_val[`PPS_ST_TIMEOUT] = EPP_ENABLE ? timeout_r : 1'b1;
      st_val[`PPS_ST_RSVD] = 1'b1;
      st_val[`PPS_ST_IRQ] = stat_irq_used ? irq_stat_n_r : 1'b1;
      st_val[6:3] = {ACK_N, PAPER_END, SELECTED, ERROR_N};
      st_val[7] = ~BUSY;
      ctl_val = {3'b111, ctl_r[`PPS_CTL_IRQEN], ~SELECT_IN_N_IN, INIT_N_IN, ~AUTO_FEED_N_IN,
                 ~DATA_STROBE_N_IN};
      ctl_val[5] = EPP_ENABLE ? ctl_r[`PPS_CTL_DIR] : 1'b1;
      ctl_val[7:6] = 2'b11;
      case (ADDR)
         `PPS_ADDR_DATA: begin
            rd_val = dir_in ? PORT_DATA_IN : data_latch_r;
         end
         `PPS_ADDR_STATUS: begin
            rd_val = st_val;
         end
         `PPS_ADDR_CONTROL: begin
            rd_val = ctl_val;
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
      if (EPP_ENABLE) begin
         irq_lvl = ack_fall | to_event;
      end else if (ECP_ENABLE | compat_mode) begin
         irq_lvl = ~ACK_N;
      end else begin
         irq_lvl = ~irq_stat_n_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Master reset pin states
   always @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         data_latch_r <= `PPS_DATA_RST;
         ctl_r <= `PPS_CTL_RST;
         timeout_r <= 1'b0;
         irq_stat_n_r <= 1'b1;
         ack_d_r <= 1'b1;
         epp_en_d_r <= 1'b0;
         live_r <= 1'b0;
         to_cnt_r <= {`PPS_TO_CNT_W{1'b0}};
         to_fired_r <= 1'b0;
         RDATA <= 8'h00;
         RDATA_OE <= 1'b0;
         WR_READY <= 1'b0;
         PORT_DATA_OUT <= 8'h00;
         PORT_DATA_OE <= 1'b0;
         DATA_STROBE_N_OUT <= 1'b1;
         DATA_STROBE_N_OE <= 1'b0;
         AUTO_FEED_N_OUT <= 1'b1;
         AUTO_FEED_N_OE <= 1'b0;
         SELECT_IN_N_OUT <= 1'b1;
         SELECT_IN_N_OE <= 1'b0;
         INIT_N_OUT <= 1'b0;
         INIT_N_OE <= 1'b1;
         IRQ_A_OUT <= 1'b0;
         IRQ_A_OE <= 1'b0;
         IRQ_B_OUT <= 1'b0;
         IRQ_B_OE <= 1'b0;
         EPP_REV_1284_OUT <= 1'b0;
      end else begin
         ack_d_r <= ACK_N;
         epp_en_d_r <= EPP_ENABLE;
         live_r <= 1'b1;
         EPP_REV_1284_OUT <= EPP_ENABLE & EPP_REV_1284;
         if (fifo_valid & ~PORT_HOLD) begin
            data_latch_r <= fifo_data;
         end
         if (WR & (ADDR == `PPS_ADDR_CONTROL)) begin
            ctl_r <= WDATA[5:0];
         end
         // ENHANCED_PORT_MODE wait counter
         if (EPP_ENABLE & EPP_CYCLE_WAIT) begin
            if (to_event) begin
               to_fired_r <= 1'b1;
            end else if (~to_fired_r) begin
               to_cnt_r <= to_cnt_r + 1'b1;
            end
         end else begin
            to_cnt_r <= {`PPS_TO_CNT_W{1'b0}};
            to_fired_r <= 1'b0;
         end
         // Timeout set wins over read clear
         if (to_event) begin
            timeout_r <= 1'b1;
         end else if (rd_status | (EPP_ENABLE & ~epp_en_d_r)) begin
            timeout_r <= 1'b0;
         end
         if (BIDIR_MODE_SELECT & ctl_r[`PPS_CTL_IRQEN] & ack_rise) begin
            irq_stat_n_r <= 1'b0;
         end else if (rd_status) begin
            irq_stat_n_r <= 1'b1;
         end
         RDATA <= rd_val;
         RDATA_OE <= RD & (ADDR != `PPS_ADDR_NONE);
         WR_READY <= fifo_ready;
         PORT_DATA_OUT <= data_latch_r;
         PORT_DATA_OE <= ~dir_in;
         DATA_STROBE_N_OUT <= ~ctl_r[`PPS_CTL_STROBE];
         AUTO_FEED_N_OUT <= ~ctl_r[`PPS_CTL_AUTOFEED];
         SELECT_IN_N_OUT <= ~ctl_r[`PPS_CTL_SELIN];
         INIT_N_OUT <= ctl_r[`PPS_CTL_INIT];
         DATA_STROBE_N_OE <= live_r;
         AUTO_FEED_N_OE <= live_r;
         SELECT_IN_N_OE <= live_r;
         INIT_N_OE <= 1'b1;
         IRQ_A_OUT <= irq_lvl;
         IRQ_B_OUT <= irq_lvl;
         IRQ_A_OE <= ctl_r[`PPS_CTL_IRQEN] & ~IRQ_LINE_SELECT;
         IRQ_B_OE <= ctl_r[`PPS_CTL_IRQEN] & IRQ_LINE_SELECT;
      end
   end
endmodule // pps_port
